/* core/bsr_defines.vh */
`ifndef BSR_DEFINES_VH
`define BSR_DEFINES_VH

// Register widths
`define BSR_IR_W 8
`define BSR_CELLS_W 18
`define BSR_OPSEL_W 2

// Reset and capture values
`define BSR_IR_RESET 8'hFF
`define BSR_IR_CAPTURE 8'h81
`define BSR_OPSEL_RESET 2'h2
`define BSR_BYPASS_CAPTURE 1'h0

// Boundary cell positions
`define BSR_CELL_CLK 17
`define BSR_CELL_OE 16
`define BSR_CELL_D_HI 15
`define BSR_CELL_D_LO 8
`define BSR_CELL_Q_HI 7
`define BSR_CELL_Q_LO 0

// Opcodes, bit 7 ignored
`define BSR_OP_BSCAN_A 7'h00
`define BSR_OP_BYPASS 7'h01
`define BSR_OP_SAMPLE 7'h02
`define BSR_OP_BSCAN_B 7'h03
`define BSR_OP_FLOAT 7'h06
`define BSR_OP_HOLD 7'h07
`define BSR_OP_RUN_TEST 7'h09
`define BSR_OP_READ_N 7'h0A
`define BSR_OP_READ_T 7'h0B
`define BSR_OP_SELF_TEST 7'h0C
`define BSR_OP_TOGGLE 7'h0D
`define BSR_OP_CTRL_N 7'h0E
`define BSR_OP_CTRL_T 7'h0F

// Test operation select codes
`define BSR_TOP_SAMPLE_TOGGLE 2'h0
`define BSR_TOP_PATTERN 2'h1
`define BSR_TOP_SIGNATURE 2'h2
`define BSR_TOP_BOTH 2'h3

// Selected data register
`define BSR_SEL_BYPASS 2'h0
`define BSR_SEL_CELLS 2'h1
`define BSR_SEL_OPSEL 2'h2

// Operating modes
`define BSR_MODE_NORMAL 2'h0
`define BSR_MODE_TEST 2'h1
`define BSR_MODE_FLOAT 2'h2

`endif

/* core/bsr_test_regs.v */
`timescale 1ns/1ps
`include "bsr_defines.vh"

// Operation
// - Shift chain plus latches; bypass shift only
// - Capture loads selected shift stage per instruction
// - Shift moves one bit per test clock
// - Update copies shift stage into latches
// - Eight-bit instruction, no parity, decodes the low seven bits
// - Opcode bit 7 ignored
// - Unassigned opcodes execute as bypass
// - Instruction capture loads 10000001
// - New instruction effective only at update
// - Reset forces instruction to all ones
// - Eighteen cells, TDI to 17, 0 to TDO
// - Cell map: clock, enable, inputs, outputs
// - Cells follow instruction, untouched by controller reset
// - Two-bit select keeps value on capture
// - Select resets to 10
// - Select acts only under run test
// - Bypass bit captures 0
// - Boundary and bypass opcode decode
// - Float command: bypass, outputs high impedance
// - Hold command: bypass, test mode
// - Run, self test, toggle decode
// - Read and select-scan opcode decode
// - TDO enables on falling edge, LSB first
// - Sample on rise, TDO and update on fall
module bsr_test_regs (
  // System clock and reset
  input wire clk_sys,
  input wire rst,
  // Test access port pins
  input wire tck,
  input wire tms,
  input wire tdi,
  output reg tdo_o,
  output reg tdo_oe,
  // Device input pins
  input wire clk_pin,
  input wire oe_n_pin,
  input wire [7:0] data_in_n,
  // Outputs of the normal flip-flop logic
  input wire [7:0] core_q,
  // Values applied to the normal logic
  output reg logic_clk,
  output reg logic_oe_n,
  output reg [7:0] logic_d,
  // Device output pins
  output reg [7:0] data_out_n,
  output reg data_out_oe,
  // Status
  output reg test_mode,
  output reg [7:0] instruction_reg,
  output reg [1:0] test_op_select_reg,
  output reg [17:0] boundary_cells_reg
);

  // Controller states
  localparam [3:0] ST_RESET = 4'h0;
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_SEL_DR = 4'h2;
  localparam [3:0] ST_CAP_DR = 4'h3;
  localparam [3:0] ST_SH_DR = 4'h4;
  localparam [3:0] ST_EX1_DR = 4'h5;
  localparam [3:0] ST_PA_DR = 4'h6;
  localparam [3:0] ST_EX2_DR = 4'h7;
  localparam [3:0] ST_UPD_DR = 4'h8;
  localparam [3:0] ST_SEL_IR = 4'h9;
  localparam [3:0] ST_CAP_IR = 4'hA;
  localparam [3:0] ST_SH_IR = 4'hB;
  localparam [3:0] ST_EX1_IR = 4'hC;
  localparam [3:0] ST_PA_IR = 4'hD;
  localparam [3:0] ST_EX2_IR = 4'hE;
  localparam [3:0] ST_UPD_IR = 4'hF;

  // Synchronisers for pins
  reg tck_s1_q, tck_s2_q, tck_s3_q;
  reg tms_s1_q, tms_s2_q;
  reg tdi_s1_q, tdi_s2_q;
  reg [9:0] pin_s1_q, pin_s2_q;

  // Controller and test registers
  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [7:0] ir_shift_q;
  reg [7:0] ir_q;
  reg [17:0] cells_shift_q;
  reg [17:0] cells_q;
  reg [1:0] opsel_shift_q;
  reg [1:0] opsel_q;
  reg bypass_q;

  // Decoded instruction
  reg [1:0] sel_d;
  reg [1:0] mode_d;
  reg cap_pins;
  reg cap_invert;
  reg is_run;
  reg is_toggle;
  wire [6:0] opcode;
  wire tck_rise;
  wire tck_fall;
  wire [17:0] pin_view;
  reg tdo_bit;

  // Two flops per outside input, three on the test clock
  always @(posedge clk_sys) begin
    if (rst) begin
      tck_s1_q <= 1'h0;
      tck_s2_q <= 1'h0;
      tck_s3_q <= 1'h0;
      tms_s1_q <= 1'h1;
      tms_s2_q <= 1'h1;
      tdi_s1_q <= 1'h1;
      tdi_s2_q <= 1'h1;
      pin_s1_q <= 10'h000;
      pin_s2_q <= 10'h000;
    end else begin
      tck_s1_q <= tck;
      tck_s2_q <= tck_s1_q;
      tck_s3_q <= tck_s2_q;
      tms_s1_q <= tms;
      tms_s2_q <= tms_s1_q;
      tdi_s1_q <= tdi;
      tdi_s2_q <= tdi_s1_q;
      pin_s1_q <= {clk_pin, oe_n_pin, data_in_n};
      pin_s2_q <= pin_s1_q;
    end
  end

  // Test clock edges seen on the system clock
  assign tck_rise = tck_s2_q & ~tck_s3_q;
  assign tck_fall = ~tck_s2_q & tck_s3_q;

  // Pin view in cell order: clock, enable, inputs, normal outputs
  assign pin_view = {pin_s2_q, core_q};

  // Bit 7 never reaches the decoder
  assign opcode = ir_q[6:0];

  // Instruction decode: register, mode and capture source
  always @* begin
    sel_d = `BSR_SEL_BYPASS;
    mode_d = `BSR_MODE_NORMAL;
    cap_pins = 1'b0;
    cap_invert = 1'b0;
    is_run = 1'b0;
    is_toggle = 1'b0;
    case (opcode)
      `BSR_OP_BSCAN_A, `BSR_OP_BSCAN_B: begin
        sel_d = `BSR_SEL_CELLS;
        mode_d = `BSR_MODE_TEST;
        cap_pins = 1'b1;
      end
      `BSR_OP_SAMPLE: begin
        sel_d = `BSR_SEL_CELLS;
        cap_pins = 1'b1;
      end
      `BSR_OP_BYPASS: begin
        sel_d = `BSR_SEL_BYPASS;
      end
      `BSR_OP_FLOAT: begin
        mode_d = `BSR_MODE_FLOAT;
      end
      `BSR_OP_HOLD: begin
        mode_d = `BSR_MODE_TEST;
      end
      `BSR_OP_RUN_TEST: begin
        mode_d = `BSR_MODE_TEST;
        is_run = 1'b1;
      end
      `BSR_OP_SELF_TEST: begin
        sel_d = `BSR_SEL_CELLS;
        cap_invert = 1'b1;
      end
      `BSR_OP_TOGGLE: begin
        mode_d = `BSR_MODE_TEST;
        is_toggle = 1'b1;
      end
      `BSR_OP_READ_N: begin
        sel_d = `BSR_SEL_CELLS;
      end
      `BSR_OP_READ_T: begin
        sel_d = `BSR_SEL_CELLS;
        mode_d = `BSR_MODE_TEST;
      end
      `BSR_OP_CTRL_N: begin
        sel_d = `BSR_SEL_OPSEL;
      end
      `BSR_OP_CTRL_T: begin
        sel_d = `BSR_SEL_OPSEL;
        mode_d = `BSR_MODE_TEST;
      end
      default: begin
        sel_d = `BSR_SEL_BYPASS;
        mode_d = `BSR_MODE_NORMAL;
      end
    endcase
  end

  // Controller next state, taken from TMS at the rising edge
  always @* begin
    case (state_q)
      ST_RESET: state_d = tms_s2_q ? ST_RESET : ST_IDLE;
      ST_IDLE: state_d = tms_s2_q ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_d = tms_s2_q ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_d = tms_s2_q ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: state_d = tms_s2_q ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: state_d = tms_s2_q ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR: state_d = tms_s2_q ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: state_d = tms_s2_q ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: state_d = tms_s2_q ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_d = tms_s2_q ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: state_d = tms_s2_q ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: state_d = tms_s2_q ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: state_d = tms_s2_q ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR: state_d = tms_s2_q ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: state_d = tms_s2_q ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: state_d = tms_s2_q ? ST_SEL_DR : ST_IDLE;
      default: state_d = ST_RESET;
    endcase
  end

  // Controller state advances on rising test clock
  always @(posedge clk_sys) begin
    if (rst) begin
      state_q <= ST_RESET;
    end else if (tck_rise) begin
      state_q <= state_d;
    end
  end

  // Instruction shift stage and latches
  always @(posedge clk_sys) begin
    if (rst) begin
      ir_shift_q <= `BSR_IR_RESET;
      ir_q <= `BSR_IR_RESET;
    end else begin
      if (tck_rise && state_q == ST_CAP_IR) begin
        ir_shift_q <= `BSR_IR_CAPTURE;
      end else if (tck_rise && state_q == ST_SH_IR) begin
        ir_shift_q <= {tdi_s2_q, ir_shift_q[7:1]};
      end
      if (tck_fall && state_q == ST_RESET) begin
        ir_q <= `BSR_IR_RESET;
      end else if (tck_fall && state_q == ST_UPD_IR) begin
        ir_q <= ir_shift_q;
      end
    end
  end

  // Test operation select shift stage and latches
  always @(posedge clk_sys) begin
    if (rst) begin
      opsel_shift_q <= `BSR_OPSEL_RESET;
      opsel_q <= `BSR_OPSEL_RESET;
    end else begin
      if (tck_rise && state_q == ST_CAP_DR && sel_d == `BSR_SEL_OPSEL) begin
        opsel_shift_q <= opsel_q;
      end else if (tck_rise && state_q == ST_SH_DR && sel_d == `BSR_SEL_OPSEL) begin
        opsel_shift_q <= {tdi_s2_q, opsel_shift_q[1]};
      end
      if (tck_fall && state_q == ST_RESET) begin
        opsel_q <= `BSR_OPSEL_RESET;
      end else if (tck_fall && state_q == ST_UPD_DR && sel_d == `BSR_SEL_OPSEL) begin
        opsel_q <= opsel_shift_q;
      end
    end
  end

  // Bypass bit: shift stage only, no latch
  always @(posedge clk_sys) begin
    if (rst) begin
      bypass_q <= `BSR_BYPASS_CAPTURE;
    end else if (tck_rise && sel_d == `BSR_SEL_BYPASS) begin
      if (state_q == ST_CAP_DR) begin
        bypass_q <= `BSR_BYPASS_CAPTURE;
      end else if (state_q == ST_SH_DR) begin
        bypass_q <= tdi_s2_q;
      end
    end
  end

  // Boundary cell shift stage; controller reset leaves contents alone
  always @(posedge clk_sys) begin
    if (rst) begin
      cells_shift_q <= 18'h00000;
    end else if (tck_rise) begin
      if (state_q == ST_CAP_DR && sel_d == `BSR_SEL_CELLS) begin
        if (cap_pins) begin
          cells_shift_q <= pin_view;
        end else if (cap_invert) begin
          cells_shift_q <= ~cells_q;
        end
      end else if (state_q == ST_SH_DR && sel_d == `BSR_SEL_CELLS) begin
        cells_shift_q <= {tdi_s2_q, cells_shift_q[17:1]};
      end else if (state_q == ST_IDLE && is_toggle) begin
        cells_shift_q[7:0] <= ~cells_shift_q[7:0];
      end else if (state_q == ST_IDLE && is_run &&
                   opsel_q == `BSR_TOP_SAMPLE_TOGGLE) begin
        cells_shift_q[15:8] <= pin_s2_q[7:0];
        cells_shift_q[7:0] <= ~cells_shift_q[7:0];
      end
    end
  end

  // Boundary cell latches, updated on falling test clock
  always @(posedge clk_sys) begin
    if (rst) begin
      cells_q <= 18'h00000;
    end else if (tck_fall) begin
      if (state_q == ST_UPD_DR && sel_d == `BSR_SEL_CELLS) begin
        cells_q <= cells_shift_q;
      end else if (state_q == ST_IDLE && is_toggle) begin
        cells_q[7:0] <= cells_shift_q[7:0];
      end else if (state_q == ST_IDLE && is_run &&
                   opsel_q == `BSR_TOP_SAMPLE_TOGGLE) begin
        cells_q[15:0] <= cells_shift_q[15:0];
      end
    end
  end

  // Serial output bit of the register in the path
  always @* begin
    if (state_q == ST_SH_IR) begin
      tdo_bit = ir_shift_q[0];
    end else begin
      case (sel_d)
        `BSR_SEL_CELLS: tdo_bit = cells_shift_q[0];
        `BSR_SEL_OPSEL: tdo_bit = opsel_shift_q[0];
        default: tdo_bit = bypass_q;
      endcase
    end
  end

  // TDO changes and enables only on falling test clock
  always @(posedge clk_sys) begin
    if (rst) begin
      tdo_o <= 1'h0;
      tdo_oe <= 1'h0;
    end else if (tck_fall) begin
      tdo_oe <= (state_q == ST_SH_IR) || (state_q == ST_SH_DR);
      tdo_o <= tdo_bit;
    end
  end

  // Pin and normal logic drive per operating mode
  always @(posedge clk_sys) begin
    if (rst) begin
      test_mode <= 1'h0;
      logic_clk <= 1'h0;
      logic_oe_n <= 1'h1;
      logic_d <= 8'h00;
      data_out_n <= 8'h00;
      data_out_oe <= 1'h0;
    end else if (mode_d == `BSR_MODE_TEST) begin
      test_mode <= 1'h1;
      logic_clk <= cells_q[`BSR_CELL_CLK];
      logic_oe_n <= cells_q[`BSR_CELL_OE];
      logic_d <= cells_q[`BSR_CELL_D_HI:`BSR_CELL_D_LO];
      data_out_n <= cells_q[`BSR_CELL_Q_HI:`BSR_CELL_Q_LO];
      data_out_oe <= ~cells_q[`BSR_CELL_OE];
    end else if (mode_d == `BSR_MODE_FLOAT) begin
      test_mode <= 1'h1;
      logic_clk <= pin_s2_q[9];
      logic_oe_n <= pin_s2_q[8];
      logic_d <= pin_s2_q[7:0];
      data_out_n <= core_q;
      data_out_oe <= 1'h0;
    end else begin
      test_mode <= 1'h0;
      logic_clk <= pin_s2_q[9];
      logic_oe_n <= pin_s2_q[8];
      logic_d <= pin_s2_q[7:0];
      data_out_n <= core_q;
      data_out_oe <= ~pin_s2_q[8];
    end
  end

  // Register views for status
  always @(posedge clk_sys) begin
    if (rst) begin
      instruction_reg <= `BSR_IR_RESET;
      test_op_select_reg <= `BSR_OPSEL_RESET;
      boundary_cells_reg <= 18'h00000;
    end else begin
      instruction_reg <= ir_q;
      test_op_select_reg <= opsel_q;
      boundary_cells_reg <= cells_q;
    end
  end

endmodule

/* verification/bsr_test_regs_props.sv */
`timescale 1ns/1ps
module bsr_test_regs_props (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Watched signals
  input wire tck,
  input wire tdo_o,
  input wire tdo_oe,
  input wire logic_clk,
  input wire logic_oe_n,
  input wire data_out_oe,
  input wire test_mode,
  input wire [7:0] instruction_reg,
  input wire [1:0] test_op_select_reg,
  input wire [17:0] boundary_cells_reg
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Opcode without its ignored top bit
  wire [6:0] op = instruction_reg[6:0];

  a_reset_values: assert property ($fell(rst) |->
    instruction_reg == 8'hFF && test_op_select_reg == 2'h2 && !tdo_oe)
    else $error("reset values wrong");
  a_tdo_on_fall: assert property ($changed(tdo_o) || $rose(tdo_oe) |-> !tck)
    else $error("data out moved while test clock high");
  a_ir_on_fall: assert property ($changed(instruction_reg) |-> !$past(tck, 2))
    else $error("instruction changed while test clock high");
  a_float_mode: assert property ((op == 7'h06) [*3] |-> test_mode && !data_out_oe)
    else $error("float command did not release outputs");
  a_normal_mode: assert property ((op == 7'h01 || op > 7'h0F) [*3] |-> !test_mode)
    else $error("bypass opcode left normal mode");
  a_test_mode: assert property ((op == 7'h00 || op == 7'h03 || op == 7'h07
    || op == 7'h09) [*3] |-> test_mode)
    else $error("test opcode without test mode");
  a_cell_controls: assert property ((op == 7'h00 && $stable(boundary_cells_reg)) [*3]
    |-> logic_clk == boundary_cells_reg[17] && logic_oe_n == boundary_cells_reg[16]
    && data_out_oe == !boundary_cells_reg[16])
    else $error("control cells not applied");
  a_bypass_cells: assert property ((op == 7'h01 || op > 7'h0F) [*2]
    |-> $stable(boundary_cells_reg))
    else $error("cells changed under bypass");
  a_select_hold: assert property ($changed(test_op_select_reg) |->
    $past(op) == 7'h0E || $past(op) == 7'h0F || instruction_reg == 8'hFF)
    else $error("select changed without its scan");
endmodule

bind bsr_test_regs bsr_test_regs_props i_bsr_test_regs_props (.clk_sys, .rst, .tck,
  .tdo_o, .tdo_oe, .logic_clk, .logic_oe_n, .data_out_oe, .test_mode, .instruction_reg,
  .test_op_select_reg, .boundary_cells_reg);

/* verification/bsr_tap_master.sv */
`timescale 1ns/1ps
module bsr_tap_master (
  // Pacing clock
  input wire clk_sys,
  // Test access port
  output reg tck,
  output reg tms,
  output reg tdi,
  input wire tdo_o,
  input wire tdo_oe
);
  // Idle levels; mode high as its pull-up would hold it
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // One test clock: levels set with clock low, data out taken just before the rise
  task step(input t, input d, output q);
    begin
      @(posedge clk_sys) #1;
      tck = 1'b0;
      tms = t;
      tdi = d;
      repeat (4) @(posedge clk_sys);
      #1;
      q = tdo_oe ? tdo_o : 1'bz;
      tck = 1'b1;
      repeat (3) @(posedge clk_sys);
      // Hand back just after the edge so callers never race the design
      #1;
    end
  endtask

  // Five highs reach reset, then settle in idle
  task tlr;
    reg q;
    begin
      repeat (5) step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
    end
  endtask

  // Scan n bits from idle back to idle, least significant first
  task scan(input ir, input integer n, input [17:0] din, output [17:0] dout);
    integer i;
    reg q;
    begin
      dout = 18'h0;
      step(1'b1, 1'b1, q);
      if (ir)
        step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
      step(1'b0, 1'b1, q);
      for (i = 0; i < n; i = i + 1) begin
        step(i == n - 1, din[i], q);
        dout[i] = q;
      end
      step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
    end
  endtask
endmodule

/* verification/bsr_test_regs_tb.sv */
`timescale 1ns/1ps
module bsr_test_regs_tb;
  // Opcodes that select bypass, and their expected test mode
  localparam [79:0] BY_OPS = {8'h81, 8'h0D, 8'h09, 8'h07, 8'h06, 8'h7F, 8'h10, 8'h08, 8'h85,
    8'h04};
  localparam [9:0] BY_TM = 10'b0111100000;
  reg clk_sys = 1'b0;
  reg rst = 1'b1;
  reg clk_pin = 1'b0;
  reg oe_n_pin = 1'b1;
  reg [7:0] data_in_n = 8'h00;
  reg [7:0] core_q = 8'h00;
  wire tck, tms, tdi, tdo_o, tdo_oe, logic_clk, logic_oe_n, data_out_oe, test_mode;
  wire [7:0] logic_d, data_out_n, instruction_reg;
  wire [1:0] test_op_select_reg;
  wire [17:0] boundary_cells_reg;
  reg [17:0] sh;
  reg [17:0] snap;
  integer err_count = 0;
  integer total_checks = 0;
  integer cyc = 0;
  integer k;

  bsr_test_regs i_bsr_test_regs (.clk_sys(clk_sys), .rst(rst), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .clk_pin(clk_pin), .oe_n_pin(oe_n_pin),
    .data_in_n(data_in_n), .core_q(core_q), .logic_clk(logic_clk), .logic_oe_n(logic_oe_n),
    .logic_d(logic_d), .data_out_n(data_out_n), .data_out_oe(data_out_oe),
    .test_mode(test_mode), .instruction_reg(instruction_reg),
    .test_op_select_reg(test_op_select_reg), .boundary_cells_reg(boundary_cells_reg));
  bsr_tap_master i_bsr_tap_master (.clk_sys(clk_sys), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo_o(tdo_o), .tdo_oe(tdo_oe));

  // System clock
  always #25 clk_sys = ~clk_sys;

  // Cut a hang short
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      test_done;
    end
  end

  task chk(input string name, input [17:0] exp, input [17:0] got);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("BAD %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask

  // Load an instruction
  task ir(input [7:0] code);
    begin
      i_bsr_tap_master.scan(1'b1, 8, {10'h0, code}, sh);
    end
  endtask

  task test_done;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    chk("ir_reset", 8'hFF, instruction_reg);
    chk("sel_reset", 2'h2, test_op_select_reg);
    chk("oe_idle", 1'b0, tdo_oe);
    i_bsr_tap_master.tlr;
    clk_pin = 1'b1;
    oe_n_pin = 1'b0;
    data_in_n = 8'h66;
    core_q = 8'h3C;
    ir(8'h02);
    chk("ir_capture", 8'h81, sh[7:0]);
    chk("ir_latch", 8'h02, instruction_reg);
    chk("mode_sample", 1'b0, test_mode);
    chk("oe_after", 1'b0, tdo_oe);
    i_bsr_tap_master.scan(1'b0, 18, 18'h25A18, sh);
    chk("cells_capture", 18'h2663C, sh);
    chk("cells_latch", 18'h25A18, boundary_cells_reg);
    ir(8'h80);
    chk("mode_extest", 1'b1, test_mode);
    chk("pins_out", 8'h18, data_out_n);
    chk("pins_drive", 1'b1, data_out_oe);
    chk("logic_in", 8'h5A, logic_d);
    chk("logic_clk", 1'b1, logic_clk);
    chk("logic_oe", 1'b0, logic_oe_n);
    ir(8'h0A);
    chk("mode_read", 1'b0, test_mode);
    i_bsr_tap_master.scan(1'b0, 18, 18'h00000, sh);
    chk("cells_read", 18'h25A18, sh);
    ir(8'h0C);
    chk("mode_self", 1'b0, test_mode);
    i_bsr_tap_master.scan(1'b0, 18, 18'h25A18, sh);
    chk("cells_self", 18'h3FFFF, sh);
    ir(8'h0B);
    chk("mode_read_t", 1'b1, test_mode);
    chk("pins_read_t", 8'h18, data_out_n);
    i_bsr_tap_master.scan(1'b0, 18, 18'h25A18, sh);
    chk("cells_read_t", 18'h25A18, sh);
    ir(8'h0F);
    chk("mode_ctrl", 1'b1, test_mode);
    i_bsr_tap_master.scan(1'b0, 2, 18'h00001, sh);
    chk("sel_capture", 2'h2, sh[1:0]);
    chk("sel_latch", 2'h1, test_op_select_reg);
    for (k = 0; k < 10; k = k + 1) begin
      ir(BY_OPS[8 * k +: 8]);
      chk("mode_bypass", BY_TM[k], test_mode);
      if (BY_OPS[8 * k +: 8] == 8'h06)
        chk("float_oe", 1'b0, data_out_oe);
      i_bsr_tap_master.scan(1'b0, 2, 18'h00001, sh);
      chk("bypass_path", 2'h2, sh[1:0]);
    end
    snap = boundary_cells_reg;
    i_bsr_tap_master.tlr;
    chk("ir_tlr", 8'hFF, instruction_reg);
    chk("sel_tlr", 2'h2, test_op_select_reg);
    chk("cells_tlr", snap, boundary_cells_reg);
    test_done;
  end
endmodule
